// ### design/rjc_jerk_clock_regs.sv
// ramp jerk and clock frequency parameter bank with its register port
//
// Summary of operation
// - the bank keeps an unsigned 24-bit jerk that shapes the first bow of the acceleration phase.
// - the bank keeps an unsigned 24-bit jerk that shapes the second bow, ending the acceleration phase.
// - the bank keeps an unsigned 24-bit jerk that shapes the first bow of the deceleration phase.
// - the bank keeps an unsigned 24-bit jerk that shapes the second bow, ending the deceleration phase.
// - in frequency mode each jerk is a whole number of pulses per second cubed from 1 to 16 M.
// - in direct mode each jerk is the change of acceleration per clock cycle, value over two to the 53.
// - in direct mode the jerk in pulses per second cubed is value over two to the 53 times clock cubed.
// - the bank holds the frequency of the external clock in hertz to relate both units.
`timescale 1ns/1ps

module rjc_jerk_clock_regs (
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [rjc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [rjc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [rjc_pkg::DATA_W-1:0] reg_rdata,
    // global unit selection, high for direct units
    input wire logic direct_mode,
    // values for the ramp generator
    output rjc_pkg::rjc_jerk_set_s jerk_set,
    output logic [rjc_pkg::HZ_W-1:0] clock_hertz,
    output logic jerk_direct,
    output logic [rjc_pkg::NUM_JERK-1:0] jerk_updated,
    output logic clock_hz_valid
);

    // address decode

    logic [rjc_pkg::NUM_JERK-1:0] hit_jerk;
    logic hit_hz;
    logic hit_status;
    logic hit_any;
    logic [rjc_pkg::NUM_JERK-1:0] wr_jerk;
    logic wr_hz;

    // one compare per jerk register
    genvar gi;
    generate
        for (gi = 0; gi < rjc_pkg::NUM_JERK; gi = gi + 1) begin : g_hit
            assign hit_jerk[gi] = (reg_addr == rjc_pkg::ADDR_JERK[gi]);
            assign wr_jerk[gi] = reg_wr & hit_jerk[gi];
        end
    endgenerate

    // clock frequency and status decode
    assign hit_hz = (reg_addr == rjc_pkg::ADDR_CLOCK_HZ);
    assign hit_status = (reg_addr == rjc_pkg::ADDR_STATUS);
    assign hit_any = (|hit_jerk) | hit_hz | hit_status;
    assign wr_hz = reg_wr & hit_hz; // status is read only, writes to it are dropped

    // parameter storage

    logic [rjc_pkg::JERK_W-1:0] jerk_q [rjc_pkg::NUM_JERK];
    logic [rjc_pkg::HZ_W-1:0] hz_q;

    // four jerk fields, one per bow, in ramp order
    generate
        for (gi = 0; gi < rjc_pkg::NUM_JERK; gi = gi + 1) begin : g_jerk
            rjc_param_reg #(
                .WIDTH(rjc_pkg::JERK_W),
                .RESET_VAL(rjc_pkg::JERK_RESET)
            ) u_jerk (
                .clk(clk),
                .reset(reset),
                .wr_en(wr_jerk[gi]),
                .wr_data(reg_wdata[rjc_pkg::JERK_W-1:0]), // unsigned, upper byte ignored
                .value(jerk_q[gi])
            );
        end
    endgenerate

    // clock frequency in hertz, wakes up at 16 MHz
    rjc_param_reg #(
        .WIDTH(rjc_pkg::HZ_W),
        .RESET_VAL(rjc_pkg::HZ_RESET)
    ) u_clock_hz (
        .clk(clk),
        .reset(reset),
        .wr_en(wr_hz),
        .wr_data(reg_wdata[rjc_pkg::HZ_W-1:0]),
        .value(hz_q)
    );

    // unit selection and sanity checks

    logic direct_ff;
    logic nxt_direct;
    logic hz_ok;
    logic hz_ok_ff;
    logic [rjc_pkg::NUM_JERK-1:0] jerk_low;
    logic [rjc_pkg::NUM_JERK-1:0] jerk_low_ff;

    // one global setting steers all four jerks at once; same clock, no synchroniser
    assign nxt_direct = direct_mode;

    // the value is trusted as given; out-of-band values are only flagged
    assign hz_ok = (hz_q >= rjc_pkg::HZ_MIN) && (hz_q <= rjc_pkg::HZ_MAX);

    // in frequency units a zero jerk lies below the least of one pulse per second cubed;
    // in direct units zero is a legal, if useless, increment per cycle
    generate
        for (gi = 0; gi < rjc_pkg::NUM_JERK; gi = gi + 1) begin : g_low
            assign jerk_low[gi] = ~direct_ff & (jerk_q[gi] < rjc_pkg::JERK_FREQ_MIN);
        end
    endgenerate

    // mode and check flags
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            direct_ff <= 1'b0;
            hz_ok_ff <= 1'b1;
            jerk_low_ff <= '0;
        end else begin
            direct_ff <= nxt_direct;
            hz_ok_ff <= hz_ok;
            jerk_low_ff <= jerk_low;
        end
    end

    // values for the ramp generator

    rjc_pkg::rjc_jerk_set_s jerk_set_ff;
    rjc_pkg::rjc_jerk_set_s nxt_jerk_set;
    logic [rjc_pkg::HZ_W-1:0] hz_out_ff;
    logic [rjc_pkg::NUM_JERK-1:0] updated_ff;
    logic [rjc_pkg::NUM_JERK-1:0] wr_seen_ff;

    // the raw 24-bit fields pass unchanged in either unit: in direct units the ramp adds
    // value / 2^53 to its acceleration each cycle, so the field is already the per-cycle
    // increment, and in pulses per second cubed it equals that times the clock cubed
    assign nxt_jerk_set.accel_start = jerk_q[rjc_pkg::JERK_ACCEL_START];
    assign nxt_jerk_set.accel_end = jerk_q[rjc_pkg::JERK_ACCEL_END];
    assign nxt_jerk_set.decel_start = jerk_q[rjc_pkg::JERK_DECEL_START];
    assign nxt_jerk_set.decel_end = jerk_q[rjc_pkg::JERK_DECEL_END];

    // output copies so every port leaves from a flip-flop; the ramp sees a write one cycle late
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            jerk_set_ff <= '{default: rjc_pkg::JERK_RESET};
            hz_out_ff <= rjc_pkg::HZ_RESET;
            wr_seen_ff <= '0;
            updated_ff <= '0;
        end else begin
            jerk_set_ff <= nxt_jerk_set;
            hz_out_ff <= hz_q;
            wr_seen_ff <= wr_jerk; // write taken, jerk_set still shows the old value
            updated_ff <= wr_seen_ff; // pulses in the cycle the new value appears
        end
    end

    // read path

    logic [rjc_pkg::DATA_W-1:0] rd_chain [rjc_pkg::NUM_JERK+1];
    logic [rjc_pkg::DATA_W-1:0] status_word;
    logic [rjc_pkg::DATA_W-1:0] hz_word;
    logic [rjc_pkg::DATA_W-1:0] rd_word;
    logic [rjc_pkg::DATA_W-1:0] nxt_rdata;
    logic [rjc_pkg::DATA_W-1:0] rdata_ff;

    // jerk words: 24 bits in the low lanes, upper bits read as zero
    assign rd_chain[0] = '0;
    generate
        for (gi = 0; gi < rjc_pkg::NUM_JERK; gi = gi + 1) begin : g_rd
            assign rd_chain[gi+1] = rd_chain[gi] |
                (hit_jerk[gi] ? {8'h00, jerk_q[gi]} : 32'h00000000);
        end
    endgenerate

    // clock frequency word, 25 bits wide
    assign hz_word = {7'h00, hz_q};

    // status: unit in use, clock value within band, jerks below the frequency minimum
    assign status_word[rjc_pkg::STAT_DIRECT_BIT] = direct_ff;
    assign status_word[rjc_pkg::STAT_HZ_OK_BIT] = hz_ok_ff;
    assign status_word[rjc_pkg::STAT_LOW_LSB +: rjc_pkg::NUM_JERK] = jerk_low_ff;
    assign status_word[rjc_pkg::DATA_W-1:rjc_pkg::STAT_W] = '0; // upper bits read as zero

    // select the addressed word, zero for an unmapped address
    assign rd_word = rd_chain[rjc_pkg::NUM_JERK] |
        (hit_hz ? hz_word : 32'h00000000) |
        (hit_status ? status_word : 32'h00000000);

    // data stand only in the cycle after the read strobe
    assign nxt_rdata = (reg_rd & hit_any) ? rd_word : 32'h00000000;

    // read data register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_ff <= 32'h00000000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // outputs

    assign reg_rdata = rdata_ff;
    assign jerk_set = jerk_set_ff;
    assign clock_hertz = hz_out_ff;
    assign jerk_direct = direct_ff;
    assign jerk_updated = updated_ff;
    assign clock_hz_valid = hz_ok_ff;

endmodule : rjc_jerk_clock_regs

// ### design/rjc_pkg.sv
// package: register map, field layout and reset values of the ramp jerk and clock bank
package rjc_pkg;

    // register port and field widths, jerk count
    localparam int ADDR_W = 7;
    localparam int DATA_W = 32;
    localparam int JERK_W = 24;
    localparam int HZ_W = 25;
    localparam int NUM_JERK = 4;
    localparam int STAT_W = 6;

    // register offsets, used directly as word addresses on the register port
    localparam logic [ADDR_W-1:0] ADDR_ACCEL_START = 7'h2D;
    localparam logic [ADDR_W-1:0] ADDR_ACCEL_END = 7'h2E;
    localparam logic [ADDR_W-1:0] ADDR_DECEL_START = 7'h2F;
    localparam logic [ADDR_W-1:0] ADDR_DECEL_END = 7'h30;
    localparam logic [ADDR_W-1:0] ADDR_CLOCK_HZ = 7'h31;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 7'h7E;

    // jerk register offsets by jerk index
    localparam logic [ADDR_W-1:0] ADDR_JERK [NUM_JERK] = '{
        ADDR_ACCEL_START, ADDR_ACCEL_END, ADDR_DECEL_START, ADDR_DECEL_END};

    // reset values
    localparam logic [JERK_W-1:0] JERK_RESET = 24'h000000;
    localparam logic [HZ_W-1:0] HZ_RESET = 25'h0F42400;

    // supported band of the clock frequency value, in hertz
    localparam logic [HZ_W-1:0] HZ_MIN = 25'h0401640;
    localparam logic [HZ_W-1:0] HZ_MAX = 25'h1C9C380;

    // least jerk in frequency mode, in pulses per second cubed
    localparam logic [JERK_W-1:0] JERK_FREQ_MIN = 24'h000001;

    // status register field positions
    localparam int STAT_DIRECT_BIT = 0;
    localparam int STAT_HZ_OK_BIT = 1;
    localparam int STAT_LOW_LSB = 2;

    // jerk index, in ramp order
    typedef enum logic [1:0] {
        JERK_ACCEL_START = 2'h0,
        JERK_ACCEL_END = 2'h1,
        JERK_DECEL_START = 2'h2,
        JERK_DECEL_END = 2'h3
    } rjc_jerk_idx_e;

    // the four jerk values handed to the ramp generator
    typedef struct packed {
        logic [JERK_W-1:0] decel_end;
        logic [JERK_W-1:0] decel_start;
        logic [JERK_W-1:0] accel_end;
        logic [JERK_W-1:0] accel_start;
    } rjc_jerk_set_s;

endpackage : rjc_pkg

// ### design/rjc_param_reg.sv
// one software-writable parameter field with a reset value
`timescale 1ns/1ps

module rjc_param_reg #(
    parameter int WIDTH = 24,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [WIDTH-1:0] value
);

    logic [WIDTH-1:0] value_ff;
    logic [WIDTH-1:0] nxt_value;

    // a write replaces the whole field, otherwise it holds
    assign nxt_value = wr_en ? wr_data : value_ff;

    // field storage
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            value_ff <= RESET_VAL;
        end else begin
            value_ff <= nxt_value;
        end
    end

    assign value = value_ff;

endmodule : rjc_param_reg

// ### verification/rjc_jerk_clock_regs_assertions.sv
// concurrent checks on the ports of the ramp jerk and clock parameter bank
`timescale 1ns/1ps

module rjc_jerk_clock_regs_assertions (
    input wire logic clk,
    input wire logic reset,
    input wire logic [6:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic direct_mode,
    input wire rjc_pkg::rjc_jerk_set_s jerk_set,
    input wire logic [24:0] clock_hertz,
    input wire logic jerk_direct,
    input wire logic [3:0] jerk_updated,
    input wire logic clock_hz_valid
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);

    // a write strobe aimed at one register
    sequence wr_at(a);
        reg_wr && reg_addr == a;
    endsequence

    accel_start_a: assert property (wr_at(7'h2D) |=> ##1 jerk_set.accel_start == $past(reg_wdata[23:0], 2) && jerk_updated[0])
        else $error("accel start jerk not taken");
    accel_end_a: assert property (wr_at(7'h2E) |=> ##1 jerk_set.accel_end == $past(reg_wdata[23:0], 2) && jerk_updated[1])
        else $error("accel end jerk not taken");
    decel_start_a: assert property (wr_at(7'h2F) |=> ##1 jerk_set.decel_start == $past(reg_wdata[23:0], 2) && jerk_updated[2])
        else $error("decel start jerk not taken");
    decel_end_a: assert property (wr_at(7'h30) |=> ##1 jerk_set.decel_end == $past(reg_wdata[23:0], 2) && jerk_updated[3])
        else $error("decel end jerk not taken");
    clock_value_a: assert property (wr_at(7'h31) |=> ##1 clock_hertz == $past(reg_wdata[24:0], 2))
        else $error("clock value not taken");
    jerk_hold_a: assert property ($changed(jerk_set) || |jerk_updated |-> $past(reg_wr, 2) && $past(reg_addr, 2) inside {[7'h2D:7'h30]})
        else $error("jerk changed without a write");
    clock_band_a: assert property (clock_hz_valid == (clock_hertz >= 25'h0401640 && clock_hertz <= 25'h1C9C380))
        else $error("clock band flag wrong");
    unit_select_a: assert property (!$past(reset) |-> jerk_direct == $past(direct_mode))
        else $error("unit select not followed");
    status_word_a: assert property (reg_rd && reg_addr == 7'h7E |=> reg_rdata[31:6] == 26'h0 && reg_rdata[1:0] == $past({clock_hz_valid, jerk_direct}))
        else $error("status word wrong");
    unmapped_read_a: assert property (reg_rd && !(reg_addr inside {[7'h2D:7'h31], 7'h7E}) || !reg_rd |=> reg_rdata == 32'h0)
        else $error("read data not zero");
endmodule : rjc_jerk_clock_regs_assertions

bind rjc_jerk_clock_regs rjc_jerk_clock_regs_assertions rjc_jerk_clock_regs_assertions_i (.clk, .reset, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .direct_mode, .jerk_set, .clock_hertz, .jerk_direct, .jerk_updated,
    .clock_hz_valid);

// ### verification/rjc_jerk_clock_regs_tb.sv
// self-checking bench for the ramp jerk and clock parameter bank
`timescale 1ns/1ps

module rjc_jerk_clock_regs_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [6:0] reg_addr = 7'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic direct_mode = 1'b0;
    logic [31:0] reg_rdata;
    rjc_pkg::rjc_jerk_set_s jerk_set;
    logic [24:0] clock_hertz;
    logic jerk_direct;
    logic [3:0] jerk_updated;
    logic clock_hz_valid;
    logic [23:0] m_jerk [4] = '{default: 24'h0};
    logic [24:0] m_hz = 25'h0F42400;
    logic [31:0] seed = 32'h00000044;
    logic [31:0] hz_edge [6] = '{32'h00401640, 32'h0040163F, 32'h01C9C380, 32'h01C9C381, 32'hFFFFFFFF, 32'h017D7840};
    int errors = 0;
    int n_tests = 0;

    rjc_jerk_clock_regs rjc_jerk_clock_regs_i (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .direct_mode, .jerk_set, .clock_hertz, .jerk_direct, .jerk_updated, .clock_hz_valid);

    // 25 MHz clock
    always #20 clk = ~clk;

    // next random word
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // supported clock band
    function automatic logic hz_ok(input logic [24:0] h);
        return h >= 25'h0401640 && h <= 25'h1C9C380;
    endfunction : hz_ok

    // expected read word from the model
    function automatic logic [31:0] reg_exp(input logic [6:0] a);
        logic [3:0] low;
        for (int i = 0; i < 4; i++) low[i] = m_jerk[i] == 24'h0 && !direct_mode;
        if (a >= 7'h2D && a <= 7'h30) return {8'h00, m_jerk[2'(a - 7'h2D)]};
        if (a == 7'h31) return {7'h00, m_hz};
        if (a == 7'h7E) return {26'h0, low, hz_ok(m_hz), direct_mode};
        return 32'h0;
    endfunction : reg_exp

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one write cycle, model follows, then the update pulse is checked
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        logic [3:0] upd;
        upd = (a >= 7'h2D && a <= 7'h30) ? 4'(1 << (a - 7'h2D)) : 4'h0;
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (a >= 7'h2D && a <= 7'h30) m_jerk[2'(a - 7'h2D)] = d[23:0];
        if (a == 7'h31) m_hz = d[24:0];
        @(posedge clk);
        @(negedge clk);
        chk(32'(jerk_updated), 32'(upd));
        @(posedge clk);
    endtask : wr

    // one read cycle, then every output except jerk_updated against the model
    task automatic rd(input logic [6:0] a);
        logic [31:0] e;
        e = reg_exp(a);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, e);
        for (int i = 0; i < 4; i++) chk(32'(jerk_set[24*i +: 24]), 32'(m_jerk[i]));
        chk(32'(clock_hertz), 32'(m_hz));
        chk(32'({clock_hz_valid, jerk_direct}), 32'({hz_ok(m_hz), direct_mode}));
        @(posedge clk);
    endtask : rd

    task automatic tally_and_finish();
        if (errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        for (int a = 32'h2C; a <= 32'h32; a++) rd(7'(a));
        for (int a = 32'h2D; a <= 32'h30; a++) begin
            wr(7'(a), 32'hFFFFFFFF);
            rd(7'(a));
        end
        foreach (hz_edge[k]) begin
            wr(7'h31, hz_edge[k]);
            rd(7'h31);
        end
        for (int n = 0; n < 60; n++) begin
            seed = lfsr(seed);
            wr(7'h2D + 7'(seed % 6), lfsr(seed));
            rd(7'h2D + 7'(seed % 6));
        end
        wr(7'h7E, 32'hFFFFFFFF);
        wr(7'h2E, 32'h0);
        wr(7'h30, 32'hFF000000);
        for (int dm = 0; dm < 2; dm++) begin
            direct_mode <= dm[0];
            repeat (3) @(posedge clk);
            rd(7'h7E);
        end
        tally_and_finish();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
endmodule : rjc_jerk_clock_regs_tb
